// File: hdl/fpw_flash_prot.sv
// Flash program data, row source and write-protect registers with an AXI4-Lite slave.
// Assumes synchronous bus inputs; a flash array sits on the request port and answers done.
`timescale 1ns/100ps
`include "fpw_params.svh"

module fpw_flash_prot #(
	parameter int PAGE_BITS = 11
) (
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	input  wire logic [7:0]   i_awaddr,
	input  wire logic         i_awvalid,
	output logic              o_awready,
	input  wire logic [31:0]  i_wdata,
	input  wire logic [3:0]   i_wstrb,
	input  wire logic         i_wvalid,
	output logic              o_wready,
	output logic [1:0]        o_bresp,
	output logic              o_bvalid,
	input  wire logic         i_bready,
	input  wire logic [7:0]   i_araddr,
	input  wire logic         i_arvalid,
	output logic              o_arready,
	output logic [31:0]       o_rdata,
	output logic [1:0]        o_rresp,
	output logic              o_rvalid,
	input  wire logic         i_rready,
	output fpw_pkg::fpw_req_s o_req,
	output logic              o_req_valid,
	input  wire logic         i_req_done
);

	// Reset synchroniser: first stage is read only by the second.
	logic rst_m_q;
	logic rst_n_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// Registers.
	logic [31:0]         data_lo_q;
	logic [31:0]         data_hi_q;
	logic [31:0]         src_q;
	logic [31:0]         tgt_q;
	logic [3:0]          op_q;
	logic                pp_unlock_q;
	logic [23:0]         pp_addr_q;
	logic                bp_unlock_q;
	logic [2:0]          bp_bits_q;
	logic                err_q;
	fpw_pkg::fpw_state_e state_q;

	// AXI write channel holding registers.
	logic        aw_have_q;
	logic        w_have_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;

	// Merges a byte-enabled write into an old word.
	function automatic logic [31:0] fpw_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		fpw_merge = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				fpw_merge[i*8 +: 8] = nw[i*8 +: 8];
	endfunction : fpw_merge

	// Write decode: a write completes once both address and data are held and no response is pending.
	wire         wr_fire   = aw_have_q && w_have_q && !o_bvalid;
	wire [31:0]  wr_word   = fpw_merge(32'h0, w_data_q, w_strb_q);
	wire         wr_known  = (aw_addr_q <= `FPW_OFS_TARGET) && (aw_addr_q[1:0] == 2'h0);
	wire         wr_pp     = wr_fire && aw_addr_q == `FPW_OFS_PROG_PROT;
	wire         wr_bp     = wr_fire && aw_addr_q == `FPW_OFS_BOOT_PROT;
	wire         wr_ctl    = wr_fire && aw_addr_q == `FPW_OFS_CONTROL;
	wire         key_wr    = wr_fire && aw_addr_q == `FPW_OFS_STATUS;
	wire         busy      = (state_q != fpw_pkg::FPW_IDLE);
	wire         key_ok;
	wire         blocked;
	wire [31:0]  pp_merged = fpw_merge({pp_unlock_q, 7'h0, pp_addr_q}, w_data_q, w_strb_q);
	wire [31:0]  bp_merged = fpw_merge({16'h0, bp_unlock_q, 4'h0, bp_bits_q, 8'h0}, w_data_q, w_strb_q);
	wire [31:0]  ctl_merged = fpw_merge({28'h0, op_q}, w_data_q, w_strb_q);
	wire         pp_take   = wr_pp && key_ok && pp_unlock_q;
	wire         bp_take   = wr_bp && key_ok;

	fpw_key_unlock u_key (
		.i_clk      (i_clk),
		.i_rst_n    (rst_n_q),
		.i_key_wr   (key_wr),
		.i_key_data (wr_word),
		.i_any_wr   (wr_fire),
		.o_unlocked (key_ok)
	);

	fpw_prot_check #(.PAGE_BITS(PAGE_BITS)) u_chk (
		.i_addr    (tgt_q),
		.i_prot    ({pp_addr_q, bp_bits_q}),
		.o_blocked (blocked)
	);

	// Write address and data are captured independently, in either order.
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
			o_bvalid  <= 1'b0;
			o_bresp   <= 2'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= i_awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= i_wdata;
				w_strb_q <= i_wstrb;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
			if (wr_fire) begin
				o_bvalid <= 1'b1;
				o_bresp  <= wr_known ? 2'h0 : 2'h2;
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// Ready is offered only while the holding slot is empty.
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
		end else begin
			o_awready <= !aw_have_q && !(i_awvalid && o_awready);
			o_wready  <= !w_have_q && !(i_wvalid && o_wready);
		end
	end

	// Data and address registers; locked while an operation runs so the request stays stable.
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			data_lo_q <= 32'h0;
			data_hi_q <= 32'h0;
			src_q     <= 32'h0;
			tgt_q     <= 32'h0;
			op_q      <= 4'h0;
		end else if (wr_fire && !busy) begin
			if (aw_addr_q == `FPW_OFS_DATA_LOW)  data_lo_q <= fpw_merge(data_lo_q, w_data_q, w_strb_q);
			if (aw_addr_q == `FPW_OFS_DATA_HIGH) data_hi_q <= fpw_merge(data_hi_q, w_data_q, w_strb_q);
			if (aw_addr_q == `FPW_OFS_ROW_SRC)   src_q     <= fpw_merge(src_q, w_data_q, w_strb_q);
			if (aw_addr_q == `FPW_OFS_TARGET)    tgt_q     <= fpw_merge(tgt_q, w_data_q, w_strb_q);
			if (aw_addr_q == `FPW_OFS_CONTROL)   op_q      <= ctl_merged[3:0];
		end
	end

	// Reset images of the protect registers; the flags and fields below are cut from them bit by bit.
	localparam logic [31:0] PP_RST = `FPW_PP_RESET;
	localparam logic [31:0] BP_RST = `FPW_BP_RESET;

	// Protect registers: unlock flags only clear, fields move only while unlocked.
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pp_unlock_q <= PP_RST[`FPW_PP_UNLOCK_BIT];
			pp_addr_q   <= PP_RST[23:0];
			bp_unlock_q <= BP_RST[`FPW_BP_UNLOCK_BIT];
			bp_bits_q   <= BP_RST[`FPW_BP_PAGE2_BIT:`FPW_BP_PAGE0_BIT];
		end else begin
			if (pp_take) begin
				pp_addr_q   <= pp_merged[23:0];
				pp_unlock_q <= pp_unlock_q & pp_merged[`FPW_PP_UNLOCK_BIT];
			end
			if (bp_take) begin
				if (bp_unlock_q)
					bp_bits_q <= bp_merged[`FPW_BP_PAGE2_BIT:`FPW_BP_PAGE0_BIT];
				bp_unlock_q <= bp_unlock_q & bp_merged[`FPW_BP_UNLOCK_BIT];
			end
		end
	end

	// Sequencer: start, check protection, issue until the array reports done.
	wire start = wr_ctl && !busy && wr_word[`FPW_CTL_START_BIT];
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q     <= fpw_pkg::FPW_IDLE;
			o_req_valid <= 1'b0;
			o_req       <= '0;
			err_q       <= 1'b0;
		end else begin
			case (state_q)
				fpw_pkg::FPW_IDLE: begin
					if (start) begin
						state_q <= fpw_pkg::FPW_CHECK;
						err_q   <= 1'b0;
					end
				end
				fpw_pkg::FPW_CHECK: begin
					if (blocked) begin
						state_q <= fpw_pkg::FPW_IDLE;
						err_q   <= 1'b1;
					end else begin
						state_q      <= fpw_pkg::FPW_ISSUE;
						o_req_valid  <= 1'b1;
						o_req.op     <= op_q;
						o_req.target <= tgt_q;
						o_req.source <= src_q;
						o_req.data   <= {data_hi_q, data_lo_q};
					end
				end
				fpw_pkg::FPW_ISSUE: begin
					if (i_req_done) begin
						state_q     <= fpw_pkg::FPW_IDLE;
						o_req_valid <= 1'b0;
					end
				end
				default: state_q <= fpw_pkg::FPW_IDLE;
			endcase
		end
	end

	// Read path: one cycle after the address is taken.
	wire [31:0] rd_word =
		(i_araddr == `FPW_OFS_DATA_LOW)  ? data_lo_q :
		(i_araddr == `FPW_OFS_DATA_HIGH) ? data_hi_q :
		(i_araddr == `FPW_OFS_ROW_SRC)   ? src_q :
		(i_araddr == `FPW_OFS_PROG_PROT) ? {pp_unlock_q, 7'h0, pp_addr_q} :
		(i_araddr == `FPW_OFS_BOOT_PROT) ? {16'h0, bp_unlock_q, 4'h0, bp_bits_q, 8'h0} :
		(i_araddr == `FPW_OFS_CONTROL)   ? {16'h0, busy, 10'h0, err_q, op_q} :
		(i_araddr == `FPW_OFS_TARGET)    ? tgt_q : 32'h0;
	wire        rd_known = (i_araddr <= `FPW_OFS_TARGET) && (i_araddr[1:0] == 2'h0);
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0;
			o_rresp   <= 2'h0;
		end else begin
			o_arready <= !o_rvalid && !(i_arvalid && o_arready);
			if (i_arvalid && o_arready) begin
				o_rvalid <= 1'b1;
				o_rdata  <= rd_word;
				o_rresp  <= rd_known ? 2'h0 : 2'h2;
			end else if (i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// Checks.
	a_unlock_noset: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		!$past(pp_unlock_q) |-> !pp_unlock_q) else $error("program unlock flag set by software");
	a_boot_frozen: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		!$past(bp_unlock_q) |-> $stable(bp_bits_q)) else $error("boot bits changed while locked");
	a_page_frozen: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		!$past(pp_unlock_q) |-> $stable(pp_addr_q)) else $error("page field changed while locked");
	a_key_needed: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(wr_pp && !key_ok) |=> $stable(pp_addr_q) && $stable(pp_unlock_q)) else $error("keyless write taken");
	a_block_stop: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(state_q == fpw_pkg::FPW_CHECK && blocked) |=> !o_req_valid && err_q) else $error("protected target issued");
	a_data_order: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		$rose(o_req_valid) |-> o_req.data == {data_hi_q, data_lo_q}) else $error("double word order wrong");
	a_src_pass: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		$rose(o_req_valid) |-> o_req.source == src_q && o_req.target == tgt_q) else $error("address mismatch");
	a_zero_open: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(pp_addr_q == 24'h0 && tgt_q[31:24] == 8'h1d) |-> !blocked) else $error("zero field still protects");
	a_boot_page2: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(tgt_q >= 32'h1fc00000 && tgt_q <= 32'h1fc007ff) |-> blocked == bp_bits_q[2]) else $error("boot page bit 10 mismatch");
	a_boot_page1: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(tgt_q >= 32'h1fc00800 && tgt_q <= 32'h1fc00fff) |-> blocked == bp_bits_q[1]) else $error("boot page bit 9 mismatch");
	a_boot_noset: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		!$past(bp_unlock_q) |-> !bp_unlock_q) else $error("boot unlock flag set by software");
	a_boot_page0: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(tgt_q == 32'h1fc01000) |-> blocked == bp_bits_q[0]) else $error("boot page bit 8 mismatch");

	// An accepted start is followed by one cycle of checking; an open target must then be issued as written.
	sequence s_op_start;
		start ##1 (state_q == fpw_pkg::FPW_CHECK);
	endsequence
	a_issue_open: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		s_op_start ##0 !blocked |=> o_req_valid && o_req.target == tgt_q && o_req.op == op_q) else $error("open target not issued");

endmodule : fpw_flash_prot

// File: hdl/fpw_key_unlock.sv
// Key unlock sequence tracker for protected register writes.
// Assumes key writes arrive as one-cycle strobes with their data.
`timescale 1ns/100ps
`include "fpw_params.svh"

module fpw_key_unlock (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_key_wr,
	input  wire logic [31:0] i_key_data,
	input  wire logic        i_any_wr,
	output logic             o_unlocked
);

	logic [1:0] stage_q;
	logic [1:0] stage_d;

	// The window closes on any other register write so a stray access cannot reuse it.
	always_comb begin
		stage_d = stage_q;
		if (i_key_wr) begin
			if (i_key_data == `FPW_KEY_FIRST)
				stage_d = 2'h1;
			else if (stage_q == 2'h1 && i_key_data == `FPW_KEY_SECOND)
				stage_d = 2'h2;
			else
				stage_d = 2'h0;
		end else if (i_any_wr) begin
			stage_d = 2'h0;
		end
	end

	// Sequence state.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			stage_q <= 2'h0;
		else
			stage_q <= stage_d;
	end

	assign o_unlocked = (stage_q == 2'h2);

endmodule : fpw_key_unlock

// File: hdl/fpw_params.svh
// Constants for the flash program and write-protect block.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz system clock.
`ifndef FPW_PARAMS_SVH
`define FPW_PARAMS_SVH

// Register byte offsets.
`define FPW_OFS_DATA_LOW     8'h00
`define FPW_OFS_DATA_HIGH    8'h04
`define FPW_OFS_ROW_SRC      8'h08
`define FPW_OFS_PROG_PROT    8'h0c
`define FPW_OFS_BOOT_PROT    8'h10
`define FPW_OFS_CONTROL      8'h14
`define FPW_OFS_STATUS       8'h18
`define FPW_OFS_TARGET       8'h1c

// Field positions.
`define FPW_PP_UNLOCK_BIT    31
`define FPW_BP_UNLOCK_BIT    15
`define FPW_BP_PAGE2_BIT     10
`define FPW_BP_PAGE1_BIT     9
`define FPW_BP_PAGE0_BIT     8
`define FPW_CTL_START_BIT    15

// Address layout of protected regions.
`define FPW_PFM_TOP_BYTE     8'h1d
`define FPW_BOOT_BASE        32'h1fc00000
`define FPW_BOOT_PAGE_BYTES  32'h00000800

// Reset values.
`define FPW_PP_RESET         32'h80000000
`define FPW_BP_RESET         32'h00008700

// Key words of the unlock sequence.
`define FPW_KEY_FIRST        32'haa996655
`define FPW_KEY_SECOND       32'h556699aa

// Operation select codes.
`define FPW_OP_DWORD         4'h2
`define FPW_OP_ROW           4'h3
`define FPW_OP_PAGE_ERASE    4'h4

`endif

// File: hdl/fpw_pkg.sv
// Types shared by the flash program and write-protect block.
// Assumes the constants header is included where offsets are needed.
package fpw_pkg;

	// One flash request handed to the flash array port.
	typedef struct packed {
		logic [3:0]  op;
		logic [31:0] target;
		logic [31:0] source;
		logic [63:0] data;
	} fpw_req_s;

	// Protection settings that steer the checker.
	typedef struct packed {
		logic [23:0] page_addr;
		logic [2:0]  boot_bits;
	} fpw_prot_s;

	// Controller sequencing states.
	typedef enum logic [1:0] {
		FPW_IDLE,
		FPW_CHECK,
		FPW_ISSUE
	} fpw_state_e;

endpackage : fpw_pkg

// File: hdl/fpw_prot_check.sv
// Combinational protection check for a flash target address.
// Assumes physical addresses and page size set by parameter.
`timescale 1ns/100ps
`include "fpw_params.svh"

module fpw_prot_check #(
	parameter int PAGE_BITS = 11
) (
	input  wire logic [31:0]       i_addr,
	input  wire fpw_pkg::fpw_prot_s i_prot,
	output logic                   o_blocked
);

	logic [31:0] limit;
	logic [31:0] limit_page;
	logic [31:0] boot_off;
	logic        in_pfm;
	logic        pfm_hit;
	logic        boot_hit;

	// A nonzero protect address rounds up to its page end, so its page and all below are covered.
	assign limit      = {`FPW_PFM_TOP_BYTE, i_prot.page_addr};
	assign limit_page = limit | ((32'h1 << PAGE_BITS) - 32'h1);
	assign in_pfm     = (i_addr[31:24] == `FPW_PFM_TOP_BYTE);
	assign pfm_hit    = in_pfm && (i_prot.page_addr != 24'h0) && (i_addr <= limit_page);

	// Boot pages: bit 10 guards the first 2 KB, bit 9 the second, bit 8 the third.
	assign boot_off = i_addr - `FPW_BOOT_BASE;
	assign boot_hit = (i_addr >= `FPW_BOOT_BASE) && (
		(boot_off < `FPW_BOOT_PAGE_BYTES && i_prot.boot_bits[2]) ||
		(boot_off >= `FPW_BOOT_PAGE_BYTES && boot_off < 32'h1000 && i_prot.boot_bits[1]) ||
		(boot_off >= 32'h1000 && boot_off < 32'h1800 && i_prot.boot_bits[0]));

	assign o_blocked = pfm_hit || boot_hit;

endmodule : fpw_prot_check

// File: testbench/fpw_flash_prot_tb.sv
// Self-checking bench for the flash program and write-protect block.
// Assumes the block alone: the bench is the AXI4-Lite master and answers the flash port itself.
`timescale 1ns/100ps
`include "fpw_params.svh"

module fpw_flash_prot_tb;

	logic              i_clk;
	logic              i_arst_n;
	logic [7:0]        i_awaddr;
	logic              i_awvalid;
	logic              o_awready;
	logic [31:0]       i_wdata;
	logic [3:0]        i_wstrb;
	logic              i_wvalid;
	logic              o_wready;
	logic [1:0]        o_bresp;
	logic              o_bvalid;
	logic              i_bready;
	logic [7:0]        i_araddr;
	logic              i_arvalid;
	logic              o_arready;
	logic [31:0]       o_rdata;
	logic [1:0]        o_rresp;
	logic              o_rvalid;
	logic              i_rready;
	fpw_pkg::fpw_req_s o_req;
	logic              o_req_valid;
	logic              i_req_done;
	int                errors;
	int                checks;
	int                i;
	logic [31:0]       rd;
	logic [1:0]        resp;
	logic [31:0]       tgt;

	fpw_flash_prot #(.PAGE_BITS(11)) dut (
		.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
		.o_req(o_req), .o_req_valid(o_req_valid), .i_req_done(i_req_done)
	);

	// Free-running 10 MHz system clock.
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// Prints the verdict once and ends the run.
	task automatic report_and_stop;
		if (errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	// Compares one value with case equality, so an unknown never matches.
	task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk32

	// One write: address and data offered together, each released when taken.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		i_awaddr  <= a;
		i_awvalid <= 1'b1;
		i_wdata   <= d;
		i_wvalid  <= 1'b1;
		i_bready  <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (i_awvalid && o_awready)
				i_awvalid <= 1'b0;
			if (i_wvalid && o_wready)
				i_wvalid <= 1'b0;
		end while (o_bvalid !== 1'b1 && n < 50);
		resp = o_bresp;
		i_bready <= 1'b0;
		if (n >= 50)
			errors++;
	endtask : axi_write

	// One read; the data and response are taken at the edge where rvalid is seen.
	task automatic axi_read(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge i_clk);
		i_araddr  <= a;
		i_arvalid <= 1'b1;
		i_rready  <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (i_arvalid && o_arready)
				i_arvalid <= 1'b0;
		end while (o_rvalid !== 1'b1 && n < 50);
		rd   = o_rdata;
		resp = o_rresp;
		i_rready <= 1'b0;
		if (n >= 50)
			errors++;
	endtask : axi_read

	// Reads a register and compares the whole word.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		axi_read(a);
		chk32(name, exp, rd);
	endtask : rd_chk

	// Key sequence; the very next write is the protected one.
	task automatic unlock;
		axi_write(`FPW_OFS_STATUS, `FPW_KEY_FIRST);
		axi_write(`FPW_OFS_STATUS, `FPW_KEY_SECOND);
	endtask : unlock

	// Starts an operation and either serves the request or expects the error flag instead.
	task automatic run_op(input logic [3:0] op, input logic [31:0] t, input bit ok);
		int n;
		axi_write(`FPW_OFS_TARGET, t);
		axi_write(`FPW_OFS_CONTROL, 32'h00008000 | {28'h0, op});
		n = 0;
		while (o_req_valid !== 1'b1 && n < 8) begin
			@(posedge i_clk);
			n++;
		end
		chk32("request issued", {31'h0, ok}, {31'h0, o_req_valid});
		if (ok) begin
			chk32("request op", {28'h0, op}, {28'h0, o_req.op});
			chk32("request target", t, o_req.target);
			chk32("request source", 32'h20000100, o_req.source);
			chk32("request data high", 32'h33334444, o_req.data[63:32]);
			chk32("request data low", 32'h11112222, o_req.data[31:0]);
			i_req_done <= 1'b1;
			@(posedge i_clk);
			i_req_done <= 1'b0;
			repeat (3) @(posedge i_clk);
			chk32("request released", 32'h0, {31'h0, o_req_valid});
		end else begin
			axi_read(`FPW_OFS_CONTROL);
			chk32("error flag", 32'h1, {31'h0, rd[4]});
		end
	endtask : run_op

	// Main sequence of register and flash operations.
	initial begin
		errors     = 0;
		checks     = 0;
		i_arst_n   = 1'b0;
		i_awaddr   = 8'h00;
		i_awvalid  = 1'b0;
		i_wdata    = 32'h0;
		i_wstrb    = 4'hf;
		i_wvalid   = 1'b0;
		i_bready   = 1'b0;
		i_araddr   = 8'h00;
		i_arvalid  = 1'b0;
		i_rready   = 1'b0;
		i_req_done = 1'b0;
		repeat (6) @(posedge i_clk);
		i_arst_n <= 1'b1;
		repeat (6) @(posedge i_clk);
		rd_chk(`FPW_OFS_PROG_PROT, `FPW_PP_RESET, "program protect reset");
		rd_chk(`FPW_OFS_BOOT_PROT, `FPW_BP_RESET, "boot protect reset");
		rd_chk(`FPW_OFS_DATA_LOW, 32'h0, "data low reset");
		rd_chk(`FPW_OFS_ROW_SRC, 32'h0, "row source reset");
		axi_write(`FPW_OFS_DATA_LOW, 32'h11112222);
		axi_write(`FPW_OFS_DATA_HIGH, 32'h33334444);
		axi_write(`FPW_OFS_ROW_SRC, 32'h20000100);
		chk32("write response", 32'h0, {30'h0, resp});
		rd_chk(`FPW_OFS_DATA_HIGH, 32'h33334444, "data high readback");
		rd_chk(`FPW_OFS_ROW_SRC, 32'h20000100, "row source readback");
		run_op(`FPW_OP_DWORD, 32'h1d000000, 1'b1);
		// A protect write without the key must leave the register alone.
		axi_write(`FPW_OFS_PROG_PROT, 32'h80000fff);
		rd_chk(`FPW_OFS_PROG_PROT, 32'h80000000, "protect without key");
		unlock;
		axi_write(`FPW_OFS_PROG_PROT, 32'hff000fff);
		rd_chk(`FPW_OFS_PROG_PROT, 32'h80000fff, "protect field set");
		run_op(`FPW_OP_DWORD, 32'h1d000ff8, 1'b0);
		run_op(`FPW_OP_PAGE_ERASE, 32'h1d000000, 1'b0);
		run_op(`FPW_OP_ROW, 32'h1d001000, 1'b1);
		for (i = 0; i < 3; i++) begin
			tgt = `FPW_BOOT_BASE + i * `FPW_BOOT_PAGE_BYTES + 32'h7f8;
			run_op(`FPW_OP_DWORD, tgt, 1'b0);
		end
		unlock;
		axi_write(`FPW_OFS_BOOT_PROT, 32'h00008200);
		rd_chk(`FPW_OFS_BOOT_PROT, 32'h00008200, "boot bits changed");
		for (i = 0; i < 3; i++) begin
			tgt = `FPW_BOOT_BASE + i * `FPW_BOOT_PAGE_BYTES;
			run_op(`FPW_OP_DWORD, tgt, i != 1);
		end
		// Clearing the unlock flags freezes the fields until the next reset.
		unlock;
		axi_write(`FPW_OFS_PROG_PROT, 32'h00000fff);
		rd_chk(`FPW_OFS_PROG_PROT, 32'h00000fff, "program flag cleared");
		unlock;
		axi_write(`FPW_OFS_PROG_PROT, 32'h80000000);
		rd_chk(`FPW_OFS_PROG_PROT, 32'h00000fff, "program flag stays");
		unlock;
		axi_write(`FPW_OFS_BOOT_PROT, 32'h00000200);
		rd_chk(`FPW_OFS_BOOT_PROT, 32'h00000200, "boot flag cleared");
		unlock;
		axi_write(`FPW_OFS_BOOT_PROT, 32'h00008700);
		rd_chk(`FPW_OFS_BOOT_PROT, 32'h00000200, "boot flag stays");
		axi_write(8'h20, 32'h12345678);
		chk32("unmapped write response", 32'h2, {30'h0, resp});
		axi_read(8'h20);
		chk32("unmapped response", 32'h2, {30'h0, resp});
		chk32("unmapped data", 32'h0, rd);
		report_and_stop;
	end

	// Cuts a hang short well past the expected length of the run.
	initial begin
		repeat (30000) @(posedge i_clk);
		errors++;
		report_and_stop;
	end

endmodule : fpw_flash_prot_tb
